// ===== verilog/pbsp_pkg.sv
// Shared constants and types for the pipelined burst SRAM port
package pbsp_pkg;

  // ----------------------------------------------------------------
  // Memory geometry and pipeline
  // ----------------------------------------------------------------
  localparam int PBSP_DW = 36;
  localparam int PBSP_AW = 19;
  localparam int PBSP_LANES = 4;
  localparam int PBSP_LAT = 2;
  localparam int PBSP_BURST = 4;

  // ----------------------------------------------------------------
  // Controller register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PBSP_REG_ADDR = 8'h00;
  localparam logic [7:0] PBSP_REG_CTRL = 8'h04;
  localparam logic [7:0] PBSP_REG_STAT = 8'h08;
  localparam logic [7:0] PBSP_REG_WPAR = 8'h0c;
  localparam logic [7:0] PBSP_REG_RPAR = 8'h30;
  localparam logic [3:0] PBSP_REG_WDAT_HI = 4'h1;
  localparam logic [3:0] PBSP_REG_RDAT_HI = 4'h2;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int PBSP_CTRL_GO = 0;
  localparam int PBSP_CTRL_WRITE = 1;
  localparam int PBSP_CTRL_BEATS = 2;
  localparam int PBSP_CTRL_BWS = 4;
  localparam int PBSP_CTRL_ORDER = 8;
  localparam int PBSP_CTRL_OEOFF = 9;
  localparam int PBSP_CTRL_SLEEP = 10;
  localparam int PBSP_CTRL_STALL = 11;

  localparam logic [1:0] PBSP_RESP_OKAY = 2'b00;
  localparam logic [1:0] PBSP_RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PBSP_B_IDLE = 2'b01,
    PBSP_B_BURST = 2'b10
  } pbsp_bstate_t;

  typedef enum logic [2:0] {
    PBSP_C_IDLE = 3'b001,
    PBSP_C_ISSUE = 3'b010,
    PBSP_C_DRAIN = 3'b100
  } pbsp_cstate_t;

endpackage : pbsp_pkg

// ===== verilog/pbsp_if.sv
// Pin-level link between the SRAM port and its controller
`timescale 1ns/1ps
`default_nettype none
interface pbsp_if
  import pbsp_pkg::*;
#(
  parameter int DW = PBSP_DW,
  parameter int AW = PBSP_AW,
  parameter int LANES = PBSP_LANES
) ();
  logic [AW-1:0] addr;
  logic write_enable_n;
  logic advance_or_load_n;
  logic clock_gate_n;
  logic chip_select_first_n;
  logic chip_select_second;
  logic chip_select_third_n;
  logic [LANES-1:0] byte_write_sel_n;
  logic burst_order_interleave;
  logic output_enable_n;
  logic sleep_request;
  logic [DW-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [DW-1:0] mem_dq_o;
  logic mem_dq_oe;
  wire [DW-1:0] dq;

  // Shared data bus resolved from the two enables; with neither end
  // driving it shows the inverse of the controller word, so a read of
  // a released bus never passes as the data last written
  assign dq = mem_dq_oe ? mem_dq_o : (ctl_dq_oe ? ctl_dq_o : ~ctl_dq_o);

  modport mem (
    input addr, write_enable_n, advance_or_load_n, clock_gate_n,
    input chip_select_first_n, chip_select_second, chip_select_third_n,
    input byte_write_sel_n, burst_order_interleave, output_enable_n,
    input sleep_request, dq,
    output mem_dq_o, mem_dq_oe
  );
  modport ctl (
    output addr, write_enable_n, advance_or_load_n, clock_gate_n,
    output chip_select_first_n, chip_select_second, chip_select_third_n,
    output byte_write_sel_n, burst_order_interleave, output_enable_n,
    output sleep_request, ctl_dq_o, ctl_dq_oe,
    input dq
  );
endinterface : pbsp_if
`default_nettype wire

// ===== verilog/pbsp_sram_device.sv
// Pipelined burst SRAM memory end with registered outputs
`timescale 1ns/1ps
`default_nettype none

// How it works
// - All synchronous inputs but the burst order pin registered on rising edge
// - Data moves two cycles after its command
// - Clock gate high freezes every register
// - Deselect on load starts nothing, stops burst
// - Pipelined transfers still finish after deselect
// - Bus floats two cycles after deselect/write
// - Four-beat burst from 2-bit counter
// - Static burst order pin picks sequence
// - Load low loads address, high advances
// - Output enable disables outputs asynchronously
// - Per-lane write selects sampled with write
// - One read/write pin sampled with address
// - Back-to-back mixed traffic, no turnaround
// - Sleep input refuses new commands, powers down once drained
// - Read data registered inside the memory
// - 512K x 36 or 1M x 18 array
module pbsp_sram_device
  import pbsp_pkg::*;
#(
  parameter int DW = PBSP_DW,
  parameter int AW = PBSP_AW,
  parameter int LANES = PBSP_LANES
) (
  input wire logic aclk,
  input wire logic aresetn,
  pbsp_if.mem bus,
  output logic burst_active,
  output logic powered_down,
  output logic read_driving
);

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  // Lanes are equal slices of the word; depth follows the address
  localparam int LW = DW / LANES;
  localparam int DEPTH = 1 << AW;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Stage 1 holds the command just taken, stage 2 a write whose data
  // is due on the bus; one struct lets a stall freeze both together
  typedef struct packed {
    logic [AW-1:0] base;
    logic [1:0] count;
    logic write;
    pbsp_bstate_t bst;
    logic s1_v;
    logic s1_w;
    logic [AW-1:0] s1_a;
    logic [LANES-1:0] s1_be;
    logic s2_v;
    logic [AW-1:0] s2_a;
    logic [LANES-1:0] s2_be;
    logic [DW-1:0] dout;
    logic drive;
    logic asleep;
  } pbsp_dev_t;

  pbsp_dev_t q;
  pbsp_dev_t d;
  // Array has no reset: contents are undefined until written
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rd_word;
  logic selected;
  logic [1:0] nxt_count;
  logic [1:0] nxt_low;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Chip select decode, burst address sequencing and the pipeline
  always_comb
  begin
    d = q;
    selected = ~bus.chip_select_first_n & bus.chip_select_second &
               ~bus.chip_select_third_n;
    nxt_count = q.count + 2'd1;

    // Mode pin is used live, not registered
    if (bus.burst_order_interleave)
    begin
      nxt_low = q.base[1:0] ^ nxt_count;
    end
    else
    begin
      nxt_low = q.base[1:0] + nxt_count;
    end

    // Read path with forwarding from the write landing this edge,
    // so a read right behind a write to the same word sees new data
    rd_word = mem[q.s1_a];
    for (int i = 0; i < LANES; i++)
    begin
      if (q.s2_v && (q.s2_a == q.s1_a) && q.s2_be[i])
      begin
        rd_word[i*LW +: LW] = bus.dq[i*LW +: LW];
      end
    end

    // Gate high: every register keeps its value
    if (!bus.clock_gate_n)
    begin
      d.s1_v = 1'b0;
      d.s1_w = 1'b0;
      d.s1_be = ~bus.byte_write_sel_n;
      if (!bus.advance_or_load_n && selected && !bus.sleep_request)
      begin
        // Load a fresh address and direction
        d.base = bus.addr;
        d.count = 2'd0;
        d.write = ~bus.write_enable_n;
        d.bst = PBSP_B_BURST;
        d.s1_v = 1'b1;
        d.s1_w = ~bus.write_enable_n;
        d.s1_a = bus.addr;
      end
      else if (!bus.advance_or_load_n || bus.sleep_request)
      begin
        // Deselect: nothing new, burst dropped
        // Sleep lands here too: refused, but the pipeline drains
        d.bst = PBSP_B_IDLE;
      end
      else if (q.bst == PBSP_B_BURST)
      begin
        // Advance: next beat of the running burst
        // Past four beats the 2-bit count simply wraps
        d.count = nxt_count;
        d.s1_v = 1'b1;
        d.s1_w = q.write;
        d.s1_a = {q.base[AW-1:2], nxt_low};
      end

      // Older commands move on regardless of the new one
      d.s2_v = q.s1_v & q.s1_w;
      d.s2_a = q.s1_a;
      d.s2_be = q.s1_be;

      // Read data registered; bus released after write/deselect
      d.drive = q.s1_v & ~q.s1_w;
      if (q.s1_v && !q.s1_w)
      begin
        d.dout = rd_word;
      end
      // Power-down only once no transfer is left in flight
      d.asleep = bus.sleep_request & ~q.s1_v & ~q.s2_v;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset holds the port idle with the bus released
  // (the array itself is left alone)
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.bst <= PBSP_B_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Memory array
  // ----------------------------------------------------------------
  // Write data sampled in the second cycle after its command
  // The array sits outside the state struct so it stays an indexed
  // memory rather than one very wide packed vector
  always_ff @(posedge aclk)
  begin
    if (aresetn && !bus.clock_gate_n && q.s2_v)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (q.s2_be[i])
        begin
          mem[q.s2_a][i*LW +: LW] <= bus.dq[i*LW +: LW];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Output enable bypasses the clock so it can cut drive at once
  assign bus.mem_dq_o = q.dout;
  assign bus.mem_dq_oe = q.drive & ~bus.output_enable_n;

  // Status outputs are plain flop copies for the host side
  assign burst_active = (q.bst == PBSP_B_BURST);
  assign powered_down = q.asleep;
  assign read_driving = q.drive;

endmodule : pbsp_sram_device
`default_nettype wire

// ===== verilog/pbsp_sram_ctrl.sv
// Controller end: AXI4-Lite registers driving the SRAM pins
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pbsp_sram_ctrl
  import pbsp_pkg::*;
#(
  parameter int DW = PBSP_DW,
  parameter int AW = PBSP_AW,
  parameter int LANES = PBSP_LANES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  pbsp_if.ctl bus
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pbsp_cstate_t st;
    logic [1:0] beat;
    logic [1:0] last;
    logic [AW-1:0] a_addr;
    logic write;
    logic [LANES-1:0] bws;
    logic order;
    logic oe_off;
    logic sleep;
    logic stall;
    logic done;
    logic [3:0][31:0] wdat;
    logic [3:0][31:0] rdat;
    logic [15:0] wpar;
    logic [15:0] rpar;
    logic [AW-1:0] p_addr;
    logic p_we_n;
    logic p_adv_n;
    logic p_cs1_n;
    logic p_cs2;
    logic p_cs3_n;
    logic p_cgn;
    logic [LANES-1:0] p_bws_n;
    logic [DW-1:0] p_dq_o;
    logic p_dq_oe;
    logic drv_v;
    logic drv_w;
    logic [1:0] drv_b;
    logic p1_v;
    logic p1_w;
    logic [1:0] p1_b;
    logic p2_v;
    logic [1:0] p2_b;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wval;
    logic [3:0] wstrb;
  } pbsp_ctl_t;

  pbsp_ctl_t q;
  pbsp_ctl_t d;
  logic [35:0] word;
  logic [35:0] dqx;
  logic [31:0] cur;
  logic cur_ok;
  logic [31:0] merged;

  // ----------------------------------------------------------------
  // Register read mux, shared by reads and partial writes
  // ----------------------------------------------------------------
  function automatic logic [32:0] rd_reg(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    if (a[7:4] == PBSP_REG_WDAT_HI)
      r[31:0] = q.wdat[a[3:2]];
    else if (a[7:4] == PBSP_REG_RDAT_HI)
      r[31:0] = q.rdat[a[3:2]];
    else if (a == PBSP_REG_ADDR)
      r[31:0] = 32'(q.a_addr);
    else if (a == PBSP_REG_CTRL)
      r[31:0] = 32'({q.stall, q.sleep, q.oe_off, q.order,
                     4'(q.bws), q.last, q.write, 1'b0});
    else if (a == PBSP_REG_STAT)
      r[31:0] = {30'h0000_0000, q.done, q.st != PBSP_C_IDLE};
    else if (a == PBSP_REG_WPAR)
      r[31:0] = {16'h0000, q.wpar};
    else if (a == PBSP_REG_RPAR)
      r[31:0] = {16'h0000, q.rpar};
    else
      r[32] = 1'b0;
    return r;
  endfunction : rd_reg

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    dqx = 36'(bus.dq);
    word = {q.wpar[{q.p1_b, 2'b00} +: 4], q.wdat[q.p1_b]};
    {cur_ok, cur} = rd_reg(q.waddr);
    merged = cur;
    for (int b = 0; b < 4; b++)
    begin
      if (q.wstrb[b])
      begin
        merged[8*b +: 8] = q.wval[8*b +: 8];
      end
    end
    // Pipeline moves only on edges the memory also honours
    if (!q.p_cgn)
    begin
      d.p2_v = q.p1_v & ~q.p1_w;
      d.p2_b = q.p1_b;
      d.p1_v = q.drv_v;
      d.p1_w = q.drv_w;
      d.p1_b = q.drv_b;
      // Write data presented exactly two cycles after the command
      d.p_dq_oe = q.p1_v & q.p1_w;
      d.p_dq_o = word[DW-1:0];
      if (q.p2_v)
      begin
        d.rdat[q.p2_b] = dqx[31:0];
        d.rpar[{q.p2_b, 2'b00} +: 4] = dqx[35:32];
      end
      case (q.st)
        PBSP_C_ISSUE:
        begin
          d.p_adv_n = (q.beat != 2'd0);
          d.p_cs1_n = 1'b0;
          d.p_cs2 = 1'b1;
          d.p_cs3_n = 1'b0;
          d.p_we_n = ~q.write;
          d.p_addr = q.a_addr;
          d.p_bws_n = ~q.bws;
          d.drv_v = 1'b1;
          d.drv_w = q.write;
          d.drv_b = q.beat;
          d.beat = q.beat + 2'd1;
          if (q.beat == q.last)
            d.st = PBSP_C_DRAIN;
        end
        PBSP_C_DRAIN:
        begin
          // Deselect while the pipeline empties
          d.p_adv_n = 1'b0;
          d.p_cs1_n = 1'b1;
          d.drv_v = 1'b0;
          if (!q.drv_v && !q.p1_v && !q.p2_v)
          begin
            d.st = PBSP_C_IDLE;
            d.done = 1'b1;
          end
        end
        default:
        begin
          d.p_adv_n = 1'b0;
          d.p_cs1_n = 1'b1;
          d.drv_v = 1'b0;
        end
      endcase
    end
    // Write channels are taken independently, answered once both are in
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_got = 1'b1;
      d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_got = 1'b1;
      d.wval = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (q.aw_got && q.w_got)
    begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = cur_ok ? PBSP_RESP_OKAY : PBSP_RESP_SLVERR;
      if (q.waddr[7:4] == PBSP_REG_WDAT_HI)
        d.wdat[q.waddr[3:2]] = merged;
      else if (q.waddr == PBSP_REG_ADDR)
        d.a_addr = merged[AW-1:0];
      else if (q.waddr == PBSP_REG_WPAR)
        d.wpar = merged[15:0];
      else if (q.waddr == PBSP_REG_CTRL)
      begin
        d.write = merged[PBSP_CTRL_WRITE];
        d.last = merged[PBSP_CTRL_BEATS +: 2];
        d.bws = merged[PBSP_CTRL_BWS +: LANES];
        d.order = merged[PBSP_CTRL_ORDER];
        d.oe_off = merged[PBSP_CTRL_OEOFF];
        d.sleep = merged[PBSP_CTRL_SLEEP];
        d.stall = merged[PBSP_CTRL_STALL];
        // Start ignored while a burst is under way
        if (merged[PBSP_CTRL_GO] && q.st == PBSP_C_IDLE)
        begin
          d.st = PBSP_C_ISSUE;
          d.beat = 2'd0;
          d.done = 1'b0;
        end
      end
    end
    d.p_cgn = d.stall;
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready = ~d.w_got & ~d.bvalid;
    // Read channel: one outstanding, answer one cycle later
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready)
    begin
      {cur_ok, d.rdata} = rd_reg(s_axi_araddr);
      d.rresp = cur_ok ? PBSP_RESP_OKAY : PBSP_RESP_SLVERR;
      d.rvalid = 1'b1;
    end
    d.arready = ~d.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.st <= PBSP_C_IDLE;
      q.p_cs1_n <= 1'b1;
      q.p_we_n <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign bus.addr = q.p_addr;
  assign bus.write_enable_n = q.p_we_n;
  assign bus.advance_or_load_n = q.p_adv_n;
  assign bus.clock_gate_n = q.p_cgn;
  assign bus.chip_select_first_n = q.p_cs1_n;
  assign bus.chip_select_second = q.p_cs2;
  assign bus.chip_select_third_n = q.p_cs3_n;
  assign bus.byte_write_sel_n = q.p_bws_n;
  assign bus.burst_order_interleave = q.order;
  assign bus.output_enable_n = q.oe_off;
  assign bus.sleep_request = q.sleep;
  assign bus.ctl_dq_o = q.p_dq_o;
  assign bus.ctl_dq_oe = q.p_dq_oe;

endmodule : pbsp_sram_ctrl
`default_nettype wire

// ===== dv/pbsp_checker.sv
// Pin-level checker for the SRAM link between controller and memory
`timescale 1ns/1ps
`default_nettype none
module pbsp_checker
  import pbsp_pkg::*;
#(
  parameter int DW = PBSP_DW
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic write_enable_n,
  input wire logic advance_or_load_n,
  input wire logic clock_gate_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [DW-1:0] mem_dq_o,
  input wire logic mem_dq_oe,
  input wire logic ctl_dq_oe
);
  // ----------------------------------------------------------------
  // Decoded commands
  // ----------------------------------------------------------------
  logic sel, go, ld_rd, ld_wr, idle_cmd;
  // Sleep counts as deselect for new commands
  assign sel = !chip_select_first_n && chip_select_second &&
    !chip_select_third_n && !sleep_request;
  assign go = !clock_gate_n;
  assign ld_rd = go && !advance_or_load_n && sel && write_enable_n;
  assign ld_wr = go && !advance_or_load_n && sel && !write_enable_n;
  assign idle_cmd = go && !advance_or_load_n && !sel;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_latency: assert property (ld_rd ##1 go |=>
    output_enable_n || mem_dq_oe)
    else $error("read data not driven two cycles after load");
  a_burst_beat: assert property (ld_rd ##1
    (go && advance_or_load_n) ##1 go |=> output_enable_n || mem_dq_oe)
    else $error("advance beat not driven");
  a_write_floats: assert property (ld_wr ##1 go |=> !mem_dq_oe)
    else $error("memory drives bus in write data slot");
  a_deselect_floats: assert property (idle_cmd ##1 go |=>
    !mem_dq_oe)
    else $error("memory drives bus after deselect");
  a_oe_forces_off: assert property (output_enable_n |->
    !mem_dq_oe)
    else $error("memory drives with output disabled");
  a_stall_holds: assert property (!go ##1
    $stable(output_enable_n) |-> $stable(mem_dq_o) && $stable(mem_dq_oe))
    else $error("memory output changed during stall");
  a_ctl_wdata: assert property (ld_wr ##1 go |=> ctl_dq_oe)
    else $error("controller did not supply write data");
  a_no_clash: assert property (!(mem_dq_oe && ctl_dq_oe))
    else $error("both ends drive the data bus");

  c_read: cover property (ld_rd ##1 go ##1 mem_dq_oe);
  c_write: cover property (ld_wr ##1 go ##1 ctl_dq_oe);
  c_sleep: cover property (idle_cmd && sleep_request);
  c_stall: cover property (!go [*3]);
endmodule : pbsp_checker
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench: controller and memory joined, driven over AXI
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pbsp_pkg::*;
;
  localparam int AW = 6;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] seed, d;
  logic [1:0] r;
  logic [35:0] model [64];
  logic [35:0] wd [4];
  int miscompares, total_checks;
  logic burst_active, powered_down, read_driving;

  // ----------------------------------------------------------------
  // Design and checker
  // ----------------------------------------------------------------
  pbsp_if #(.AW(AW)) link ();
  pbsp_sram_device #(.AW(AW)) i_pbsp_sram_device (.aclk, .aresetn,
    .bus(link.mem), .burst_active, .powered_down, .read_driving);
  pbsp_sram_ctrl #(.AW(AW)) i_pbsp_sram_ctrl (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .bus(link.ctl));
  pbsp_checker #(.DW(PBSP_DW)) i_pbsp_checker (.aclk, .aresetn,
    .write_enable_n(link.write_enable_n),
    .advance_or_load_n(link.advance_or_load_n),
    .clock_gate_n(link.clock_gate_n),
    .chip_select_first_n(link.chip_select_first_n),
    .chip_select_second(link.chip_select_second),
    .chip_select_third_n(link.chip_select_third_n),
    .output_enable_n(link.output_enable_n),
    .sleep_request(link.sleep_request), .mem_dq_o(link.mem_dq_o),
    .mem_dq_oe(link.mem_dq_oe), .ctl_dq_oe(link.ctl_dq_oe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr

  // Low bits step by count, linear adds and interleaved XORs
  function automatic logic [5:0] baddr(input logic [5:0] b,
    input logic [1:0] k, input logic il);
    return {b[5:2], il ? (b[1:0] ^ k) : (b[1:0] + k)};
  endfunction : baddr

  task automatic chk(input string nm, input logic [35:0] seen,
    input logic [35:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv,
    output logic [1:0] rs);
    logic awp, wp;
    awp = 1'b1;
    wp = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dv;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awp && s_axi_awready)
      begin
        awp = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready)
      begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(s_axi_bvalid && !awp && !wp));
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv,
    output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    dv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Run one burst; ex = {stall, sleep, output disable}
  task automatic burst(input logic wr, input logic [5:0] base,
    input logic [1:0] nb, input logic [3:0] ln, input logic il,
    input logic [2:0] ex);
    logic [31:0] par, rp, dv;
    logic [1:0] rs;
    logic [5:0] ba;
    seed = lfsr(seed);
    par = seed;
    axi_wr(PBSP_REG_ADDR, {26'h0, base}, rs);
    axi_wr(PBSP_REG_WPAR, par, rs);
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      wd[k] = {par[4*k+:4], seed};
      axi_wr(8'h10 + 8'(4*k), seed, rs);
    end
    axi_wr(PBSP_REG_CTRL, {20'h0, ex, il, ln, nb, wr, 1'b1}, rs);
    if (ex[2])
    begin
      repeat (20) @(posedge aclk);
      axi_rd(PBSP_REG_STAT, dv, rs);
      chk("stalled status", 36'(dv[1:0]), 36'h1);
      axi_wr(PBSP_REG_CTRL, {23'h0, il, ln, nb, wr, 1'b0}, rs);
    end
    do axi_rd(PBSP_REG_STAT, dv, rs); while (dv[1] !== 1'b1);
    chk("burst active", 36'(burst_active), 36'h0);
    chk("read drive", 36'(read_driving), 36'h0);
    chk("power down", 36'(powered_down), 36'(ex[1]));
    axi_rd(PBSP_REG_RPAR, rp, rs);
    for (int k = 0; k <= int'(nb); k++)
    begin
      ba = baddr(base, k[1:0], il);
      if (wr && !ex[1])
        for (int i = 0; i < 4; i++)
          if (ln[i]) model[ba][9*i+:9] = wd[k][9*i+:9];
      if (!wr && ex[1:0] == 2'b00)
      begin
        axi_rd(8'h20 + 8'(4*k), dv, rs);
        chk("read beat", {rp[4*k+:4], dv}, model[ba]);
      end
    end
  endtask : burst

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Main sequence; array is not reset, so fill it before any read
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    seed = 32'h45b6;
    miscompares = 0;
    total_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int b = 0; b < 16; b++)
      burst(1'b1, 6'(4*b), 2'h3, 4'hf, 1'b0, 3'b000);
    $display("test fill done");
    for (int n = 0; n < 30; n++)
    begin
      seed = lfsr(seed);
      burst(1'b1, seed[5:0], seed[7:6], seed[11:8], seed[12], 3'b000);
      burst(1'b0, seed[5:0], seed[14:13], 4'h0, seed[15], 3'b000);
    end
    burst(1'b1, 6'h3f, 2'h3, 4'h5, 1'b1, 3'b000);
    burst(1'b0, 6'h3d, 2'h3, 4'h0, 1'b0, 3'b000);
    $display("test random bursts done");
    burst(1'b1, 6'h08, 2'h3, 4'hf, 1'b0, 3'b010);
    burst(1'b0, 6'h08, 2'h3, 4'h0, 1'b0, 3'b010);
    burst(1'b0, 6'h08, 2'h3, 4'h0, 1'b1, 3'b000);
    $display("test sleep done");
    burst(1'b0, 6'h10, 2'h3, 4'h0, 1'b0, 3'b001);
    burst(1'b0, 6'h10, 2'h1, 4'h0, 1'b0, 3'b000);
    $display("test output disable done");
    burst(1'b1, 6'h20, 2'h3, 4'hf, 1'b1, 3'b100);
    burst(1'b0, 6'h20, 2'h3, 4'h0, 1'b0, 3'b000);
    $display("test stall done");
    axi_rd(8'h40, d, r);
    chk("unmapped rresp", 36'(r), 36'(PBSP_RESP_SLVERR));
    chk("unmapped rdata", 36'(d), 36'h0);
    axi_wr(8'h44, 32'h1, r);
    chk("unmapped bresp", 36'(r), 36'(PBSP_RESP_SLVERR));
    $display("test unmapped done");
    report_and_stop();
  end

  // Watchdog well past the expected run length
  initial
  begin
    repeat (90000) @(posedge aclk);
    miscompares++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
